// File: rtl/sync_bus_pkg.sv
// constants, types and state shapes for the synchronous peripheral bus cycle
// assumes a 125 MHz system clock; the enable clock is derived from it
package sync_bus_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;

  // ------------------------------------------------------------------
  // enable clock shape, counted in system clocks (phase 0 = enable falls)
  // ------------------------------------------------------------------
  localparam logic [3:0] E_PHASE_FIRST = 4'h0;
  localparam logic [3:0] E_PHASE_LAST  = 4'h9;
  localparam logic [3:0] E_PHASE_ONE   = 4'h1;
  localparam logic [3:0] E_HIGH_FIRST  = 4'h6;
  // recognition window: best three, worst two clocks before enable rises
  localparam logic [3:0] RECOG_FIRST   = 4'h3;
  localparam logic [3:0] RECOG_LAST    = 4'h4;
  // last high clock: read data is latched here, enable falls right after
  localparam logic [3:0] LATCH_PHASE   = 4'h9;

  // ------------------------------------------------------------------
  // interrupt acknowledge
  // ------------------------------------------------------------------
  localparam logic [2:0] FC_IACK      = 3'h7;
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_WAIT_REQ, ST_SELECT, ST_S7
  } bus_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              write;
    logic              upper;
    logic              lower;
    logic [2:0]        fc;
    logic              iack;
    logic [2:0]        level;
  } bus_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [7:0]        vector;
    logic              autovec;
  } bus_rsp_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              addr_oe;
    logic [DATA_W-1:0] data;
    logic              data_oe;
    logic [2:0]        fc;
    logic              fc_oe;
    logic              addr_valid_strobe_n;
    logic              upper_byte_strobe_n;
    logic              lower_byte_strobe_n;
    logic              rw;
    logic              valid_peripheral_select_n;
  } bus_pins_type;

endpackage

// File: rtl/sync2.sv
// two flip-flop level synchroniser
// assumes d_i is a level from another domain or a pin
module sync2 (
  input  wire logic clk_i,
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic first;
    logic second;
  } sync2_state_type;

  sync2_state_type s_r;
  sync2_state_type s_nxt;

  // no reset: a reset would only delay the level by the same two edges
  always_comb begin
    s_nxt        = s_r;
    s_nxt.first  = d_i;
    s_nxt.second = s_r.first;
  end

  always_ff @(posedge clk_i) begin
    s_r <= s_nxt;
  end

  assign q_o = s_r.second;

endmodule

// File: rtl/enable_clock_gen.sv
// free running peripheral enable clock, one tenth of the system clock
// assumes a synchronous active high reset on the system clock
module enable_clock_gen (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  output logic            enable_o,
  output logic [3:0]      phase_o
);

  typedef struct packed {
    logic [3:0] phase;
    logic       e;
  } egen_state_type;

  egen_state_type s_r;
  egen_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    // runs from reset on, regardless of bus traffic
    if (s_r.phase == sync_bus_pkg::E_PHASE_LAST) begin // ten clocks per period
      s_nxt.phase = sync_bus_pkg::E_PHASE_FIRST;
    end else begin
      s_nxt.phase = s_r.phase + sync_bus_pkg::E_PHASE_ONE;
    end
    s_nxt.e = (s_nxt.phase >= sync_bus_pkg::E_HIGH_FIRST); // six low, four high
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_r.phase <= sync_bus_pkg::E_PHASE_FIRST;
      s_r.e     <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign enable_o = s_r.e;
  assign phase_o  = s_r.phase;

endmodule

// File: rtl/sync_peripheral_bus_cycle.sv
// synchronous peripheral bus cycle engine with its enable clock
// assumes a core request port on its own clock and external address decode
// that drives the synchronous peripheral request pin

module sync_peripheral_bus_cycle (
  input  wire logic                            clk_sys_i,
  input  wire logic                            rst_i,
  input  wire logic                            clk_core_i,
  input  wire logic                            core_req_valid_i,
  input  wire sync_bus_pkg::bus_req_type       core_req_i,
  output logic                                 core_busy_o,
  output logic                                 core_done_o,
  output sync_bus_pkg::bus_rsp_type            core_rsp_o,
  input  wire logic                            sync_peripheral_request_n_i,
  input  wire logic [sync_bus_pkg::DATA_W-1:0] data_i,
  output logic [sync_bus_pkg::DATA_W-1:0]      data_o,
  output logic                                 data_oe_o,
  output logic [sync_bus_pkg::ADDR_W-1:0]      addr_o,
  output logic                                 addr_oe_o,
  output logic [2:0]                           fc_o,
  output logic                                 fc_oe_o,
  output logic                                 addr_valid_strobe_n_o,
  output logic                                 upper_byte_strobe_n_o,
  output logic                                 lower_byte_strobe_n_o,
  output logic                                 rw_o,
  output logic                                 valid_peripheral_select_n_o,
  output logic                                 enable_o
);

  // ------------------------------------------------------------------
  // state shapes
  // ------------------------------------------------------------------
  typedef struct packed {
    sync_bus_pkg::bus_state_type        state;
    sync_bus_pkg::bus_req_type          req;
    sync_bus_pkg::bus_rsp_type          rsp;
    sync_bus_pkg::bus_pins_type         pins;
    logic [sync_bus_pkg::DATA_W-1:0]    din1;
    logic [sync_bus_pkg::DATA_W-1:0]    din2;
    logic                               req_seen;
    logic                               ack_tgl;
  } sys_state_type;

  typedef struct packed {
    sync_bus_pkg::bus_req_type          hold;
    sync_bus_pkg::bus_rsp_type          rsp;
    logic                               busy;
    logic                               done;
    logic                               req_tgl;
    logic                               ack_seen;
  } core_state_type;

  sys_state_type  s_r;
  sys_state_type  s_nxt;
  core_state_type c_r;
  core_state_type c_nxt;

  logic       phase_valid;
  logic [3:0] e_phase;
  logic       req_pin_n_s;
  logic       req_tgl_s;
  logic       ack_tgl_s;
  logic       rst_core_s;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic in_recog_window(input logic [3:0] phase);
    in_recog_window = (phase >= sync_bus_pkg::RECOG_FIRST) &&
                      (phase <= sync_bus_pkg::RECOG_LAST);
  endfunction

  function automatic sync_bus_pkg::bus_pins_type pins_idle();
    sync_bus_pkg::bus_pins_type p;
    p                           = '0;
    p.addr_valid_strobe_n       = 1'b1;
    p.upper_byte_strobe_n       = 1'b1;
    p.lower_byte_strobe_n       = 1'b1;
    p.rw                        = 1'b1;
    p.valid_peripheral_select_n = 1'b1;
    pins_idle                   = p;
  endfunction

  // ------------------------------------------------------------------
  // enable clock and crossings
  // ------------------------------------------------------------------
  enable_clock_gen u_egen (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .enable_o  (phase_valid),
    .phase_o   (e_phase)
  );

  sync2 u_sync_req_pin (
    .clk_i (clk_sys_i),
    .d_i   (sync_peripheral_request_n_i),
    .q_o   (req_pin_n_s)
  );

  sync2 u_sync_req_tgl (
    .clk_i (clk_sys_i),
    .d_i   (c_r.req_tgl),
    .q_o   (req_tgl_s)
  );

  sync2 u_sync_ack_tgl (
    .clk_i (clk_core_i),
    .d_i   (s_r.ack_tgl),
    .q_o   (ack_tgl_s)
  );

  sync2 u_sync_rst_core (
    .clk_i (clk_core_i),
    .d_i   (rst_i),
    .q_o   (rst_core_s)
  );

  // ------------------------------------------------------------------
  // bus engine on the system clock
  // ------------------------------------------------------------------
  logic recog;
  // async transfer ack is not watched here; outside logic keeps it off
  // request comes from outside decode qualified by address strobe
  assign recog = !req_pin_n_s && in_recog_window(e_phase);

  always_comb begin
    s_nxt      = s_r;
    // the data bus only passes two flops before anything reads it
    s_nxt.din1 = data_i;
    s_nxt.din2 = s_r.din1;
    unique case (s_r.state)
      sync_bus_pkg::ST_IDLE: begin
        if (req_tgl_s != s_r.req_seen) begin
          // the held request is stable while the core side stays busy
          s_nxt.req_seen = req_tgl_s;
          s_nxt.req      = c_r.hold;
          s_nxt.state    = sync_bus_pkg::ST_S0;
        end
      end
      sync_bus_pkg::ST_S0: begin
        s_nxt.pins.addr_oe = 1'b0;
        s_nxt.pins.fc      = s_r.req.iack ? sync_bus_pkg::FC_IACK : s_r.req.fc;
        s_nxt.pins.fc_oe   = 1'b1;
        s_nxt.state        = sync_bus_pkg::ST_S1;
      end
      sync_bus_pkg::ST_S1: begin
        s_nxt.pins.addr    = s_r.req.addr;
        s_nxt.pins.addr_oe = 1'b1;
        s_nxt.state        = sync_bus_pkg::ST_S2;
      end
      sync_bus_pkg::ST_S2: begin
        s_nxt.pins.addr_valid_strobe_n = 1'b0;
        if (s_r.req.write) begin
          s_nxt.pins.rw = 1'b0;
        end else begin
          s_nxt.pins.upper_byte_strobe_n = !s_r.req.upper;
          s_nxt.pins.lower_byte_strobe_n = !s_r.req.lower;
        end
        s_nxt.state = sync_bus_pkg::ST_S3;
      end
      sync_bus_pkg::ST_S3: begin
        if (s_r.req.write) begin
          s_nxt.pins.data    = s_r.req.wdata;
          s_nxt.pins.data_oe = 1'b1;
        end
        s_nxt.state = sync_bus_pkg::ST_S4;
      end
      sync_bus_pkg::ST_S4: begin
        if (s_r.req.write) begin
          s_nxt.pins.upper_byte_strobe_n = !s_r.req.upper;
          s_nxt.pins.lower_byte_strobe_n = !s_r.req.lower;
        end
        // a prompt request is taken here, costing only alignment waits
        if (recog) begin
          s_nxt.pins.valid_peripheral_select_n = 1'b0;
          s_nxt.state                          = sync_bus_pkg::ST_SELECT;
        end else begin
          s_nxt.state = sync_bus_pkg::ST_WAIT_REQ;
        end
      end
      sync_bus_pkg::ST_WAIT_REQ: begin
        // wait states; a request seen late waits for the next low window
        if (recog) begin
          // window lies in the low phase, so enable is low at select
          s_nxt.pins.valid_peripheral_select_n = 1'b0;
          s_nxt.state                          = sync_bus_pkg::ST_SELECT;
        end
      end
      sync_bus_pkg::ST_SELECT: begin
        // peripheral transfers while enable is high
        if (e_phase == sync_bus_pkg::LATCH_PHASE) begin
          if (!s_r.req.write) begin
            s_nxt.rsp.rdata = s_r.din2;
          end
          // edge where enable falls, for every cycle kind
          s_nxt.pins.addr_valid_strobe_n = 1'b1;
          s_nxt.pins.upper_byte_strobe_n = 1'b1;
          s_nxt.pins.lower_byte_strobe_n = 1'b1;
          s_nxt.state                    = sync_bus_pkg::ST_S7;
        end
      end
      sync_bus_pkg::ST_S7: begin
        // one clock after the strobes: release address and rw
        s_nxt.pins = pins_idle();
        // acknowledge with request is an ordinary read plus autovector
        s_nxt.rsp.autovec = s_r.req.iack;
        if (s_r.req.iack) begin
          s_nxt.rsp.vector = sync_bus_pkg::AUTOVEC_BASE + {5'h00, s_r.req.level};
        end else begin
          s_nxt.rsp.vector = s_r.rsp.rdata[7:0];
        end
        s_nxt.ack_tgl = !s_r.ack_tgl;
        s_nxt.state   = sync_bus_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_r.state    <= sync_bus_pkg::ST_IDLE;
      s_r.req      <= '0;
      s_r.rsp      <= '0;
      s_r.pins     <= pins_idle();
      s_r.din1     <= '0;
      s_r.din2     <= '0;
      s_r.req_seen <= 1'b0;
      s_r.ack_tgl  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------------
  // core side handshake on the core clock
  // ------------------------------------------------------------------
  always_comb begin
    c_nxt      = c_r;
    c_nxt.done = 1'b0;
    if (!c_r.busy && core_req_valid_i) begin
      c_nxt.hold    = core_req_i;
      c_nxt.busy    = 1'b1;
      c_nxt.req_tgl = !c_r.req_tgl;
    end
    if (c_r.busy && (ack_tgl_s != c_r.ack_seen)) begin
      // response word is stable in the system domain until the next cycle
      c_nxt.ack_seen = ack_tgl_s;
      c_nxt.rsp      = s_r.rsp;
      c_nxt.busy     = 1'b0;
      c_nxt.done     = 1'b1;
    end
  end

  // reset reaches this domain through a synchroniser; toggles restart at zero
  always_ff @(posedge clk_core_i) begin
    if (rst_core_s) begin
      c_r.hold     <= '0;
      c_r.rsp      <= '0;
      c_r.busy     <= 1'b0;
      c_r.done     <= 1'b0;
      c_r.req_tgl  <= 1'b0;
      c_r.ack_seen <= 1'b0;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign core_busy_o                 = c_r.busy;
  assign core_done_o                 = c_r.done;
  assign core_rsp_o                  = c_r.rsp;
  assign data_o                      = s_r.pins.data;
  assign data_oe_o                   = s_r.pins.data_oe;
  assign addr_o                      = s_r.pins.addr;
  assign addr_oe_o                   = s_r.pins.addr_oe;
  assign fc_o                        = s_r.pins.fc;
  assign fc_oe_o                     = s_r.pins.fc_oe;
  assign addr_valid_strobe_n_o       = s_r.pins.addr_valid_strobe_n;
  assign upper_byte_strobe_n_o       = s_r.pins.upper_byte_strobe_n;
  assign lower_byte_strobe_n_o       = s_r.pins.lower_byte_strobe_n;
  assign rw_o                        = s_r.pins.rw;
  assign valid_peripheral_select_n_o = s_r.pins.valid_peripheral_select_n;
  assign enable_o                    = phase_valid;

endmodule

// File: verif/sync_bus_chk.sv
// checker: bus cycle and enable clock timing seen at the pins
// assumes a bind to the top module; system clock domain only
module sync_bus_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sync_peripheral_request_n_i,
  input wire logic data_oe_o,
  input wire logic addr_oe_o,
  input wire logic fc_oe_o,
  input wire logic addr_valid_strobe_n_o,
  input wire logic upper_byte_strobe_n_o,
  input wire logic lower_byte_strobe_n_o,
  input wire logic rw_o,
  input wire logic valid_peripheral_select_n_o,
  input wire logic enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic both_hi = upper_byte_strobe_n_o && lower_byte_strobe_n_o;
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // --------
  // sequences
  // --------
  sequence s_head;
    !addr_oe_o && addr_valid_strobe_n_o ##1 addr_oe_o ##1 !addr_valid_strobe_n_o;
  endsequence
  sequence s_wr;
    both_hi ##1 (data_oe_o && both_hi) ##1 !both_hi;
  endsequence
  sequence s_align;
    ##[1:2] $rose(enable_o);
  endsequence
  sequence s_close;
    ($fell(enable_o) && both_hi && addr_valid_strobe_n_o) ##1
      (valid_peripheral_select_n_o && rw_o && !addr_oe_o && !data_oe_o && !fc_oe_o);
  endsequence
  // --------
  // properties
  // --------
  property p_en_low;
    $fell(enable_o) |-> (!enable_o) [*6] ##1 enable_o;
  endproperty
  property p_en_high;
    $rose(enable_o) |-> enable_o [*4] ##1 !enable_o;
  endproperty
  property p_period;
    $rose(enable_o) |-> ##10 $rose(enable_o);
  endproperty
  property p_head;
    $rose(fc_oe_o) |-> s_head;
  endproperty
  property p_read;
    $fell(addr_valid_strobe_n_o) && rw_o |-> !both_hi;
  endproperty
  property p_write;
    $fell(addr_valid_strobe_n_o) && !rw_o |-> s_wr;
  endproperty
  // select only after the request and with enable low
  property p_sel_cause;
    $fell(valid_peripheral_select_n_o) |-> !addr_valid_strobe_n_o && !enable_o
      && !$past(sync_peripheral_request_n_i, 2);
  endproperty
  property p_sel_cycle;
    $fell(valid_peripheral_select_n_o) |-> s_align ##4 s_close;
  endproperty
  property p_float;
    !addr_oe_o |-> valid_peripheral_select_n_o;
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("enable low time wrong");
  a_en_high: assert property (p_en_high)
    else $error("enable high time wrong");
  a_period: assert property (p_period)
    else $error("enable period wrong");
  a_head: assert property (p_head)
    else $error("cycle head order wrong");
  a_read: assert property (p_read)
    else $error("read strobes missing in S2");
  a_write: assert property (p_write)
    else $error("write data or strobes mistimed");
  a_sel_cause: assert property (p_sel_cause)
    else $error("select without request or with enable high");
  a_sel_cycle: assert property (p_sel_cycle)
    else $error("select to release sequence wrong");
  a_float: assert property (p_float)
    else $error("select active while bus floats");
endmodule

// File: verif/sync_periph_model.sv
// far side: address decoder plus a sixteen word synchronous peripheral
// assumes the bench changes req_delay_i only while the bus is idle
module sync_periph_model (
  input  wire logic        clk_sys_i,
  input  wire logic [4:0]  req_delay_i,
  input  wire logic [22:0] addr_i,
  input  wire logic        addr_oe_i,
  input  wire logic [2:0]  fc_i,
  input  wire logic        fc_oe_i,
  input  wire logic        addr_valid_strobe_n_i,
  input  wire logic        upper_byte_strobe_n_i,
  input  wire logic        lower_byte_strobe_n_i,
  input  wire logic        rw_i,
  input  wire logic        valid_peripheral_select_n_i,
  input  wire logic        enable_i,
  input  wire logic [15:0] data_i,
  output logic             sync_peripheral_request_n_o,
  output logic             alt_select_n_o,
  output logic [15:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16] = '{default: 16'h0000};
  logic [15:0] last_r = 16'hA5A5;
  logic [4:0]  cnt_r = 5'h00;
  logic        iack;
  logic        hit;
  logic        sel;
  logic        rd;
  logic [3:0]  a;
  assign a    = addr_i[3:0];
  assign iack = fc_oe_i && fc_i == 3'h7;
  assign sel  = enable_i && !valid_peripheral_select_n_i && !iack;
  // top eighth of the map, or any acknowledge fetch
  assign hit  = iack || (addr_oe_i && addr_i[22:20] == 3'h7);
  // select built outside, as a part without the select pin needs it
  // enable fall is seen half a clock late; all three flops move on the clock's fall
  logic        e_d_r = 1'b0;
  logic        alt1_r = 1'b0;
  logic        alt2_r = 1'b0;
  logic        decode;
  assign decode = hit && !addr_valid_strobe_n_i;
  assign alt_select_n_o = !alt2_r;
  always @(negedge clk_sys_i) begin
    e_d_r  <= enable_i;
    alt1_r <= decode && (alt1_r || (e_d_r && !enable_i));
    alt2_r <= alt1_r && decode;
  end
  // dropped with the strobe, well inside one clock
  // never answers asynchronously, so no clash with the request
  assign sync_peripheral_request_n_o = !(hit && !addr_valid_strobe_n_i && cnt_r >= req_delay_i);
  assign rd = sel && rw_i;
  // released bus shows the inverse of its last value, never a stale match
  assign data_o = rd ? mem[a] : ~last_r;
  always @(posedge clk_sys_i) begin
    cnt_r <= addr_valid_strobe_n_i ? 5'h00 : cnt_r + {4'h0, cnt_r != 5'h1F};
    if (rd) last_r <= mem[a];
    if (sel && !rw_i && !upper_byte_strobe_n_i) mem[a][15:8] <= data_i[15:8];
    if (sel && !rw_i && !lower_byte_strobe_n_i) mem[a][7:0] <= data_i[7:0];
  end
endmodule

// File: verif/sync_peripheral_bus_cycle_tb.sv
// bench: core requests on the slow clock, peripheral model on the bus
// assumes the checker is bound below and the model answers every cycle
module sync_peripheral_bus_cycle_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk_sys_i = 1'b0;
  logic                      clk_core_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic                      core_req_valid_i = 1'b0;
  sync_bus_pkg::bus_req_type core_req_i = '0;
  sync_bus_pkg::bus_rsp_type core_rsp_o;
  logic                      core_busy_o, core_done_o, sync_peripheral_request_n_i;
  logic [15:0]               data_i, data_o;
  logic [22:0]               addr_o;
  logic [2:0]                fc_o;
  logic                      data_oe_o, addr_oe_o, fc_oe_o, rw_o, enable_o;
  logic                      addr_valid_strobe_n_o, valid_peripheral_select_n_o;
  logic                      upper_byte_strobe_n_o, lower_byte_strobe_n_o;
  logic [4:0]                req_delay = 5'h00;
  logic                      alt_select_n;
  logic                      alt_seen = 1'b0;
  logic [15:0]               shadow [16] = '{default: 16'h0000};
  int                        n_mismatch = 0;
  int                        n_compared = 0;
  int                        cycles = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  always #62.5 clk_core_i = ~clk_core_i;
  sync_peripheral_bus_cycle u_sync_peripheral_bus_cycle (
    .clk_sys_i, .rst_i, .clk_core_i, .core_req_valid_i, .core_req_i, .core_busy_o,
    .core_done_o, .core_rsp_o, .sync_peripheral_request_n_i, .data_i, .data_o,
    .data_oe_o, .addr_o, .addr_oe_o, .fc_o, .fc_oe_o, .addr_valid_strobe_n_o,
    .upper_byte_strobe_n_o, .lower_byte_strobe_n_o, .rw_o,
    .valid_peripheral_select_n_o, .enable_o);
  sync_periph_model u_sync_periph_model (
    .clk_sys_i, .req_delay_i(req_delay), .addr_i(addr_o), .addr_oe_i(addr_oe_o),
    .fc_i(fc_o), .fc_oe_i(fc_oe_o), .addr_valid_strobe_n_i(addr_valid_strobe_n_o),
    .upper_byte_strobe_n_i(upper_byte_strobe_n_o),
    .lower_byte_strobe_n_i(lower_byte_strobe_n_o), .rw_i(rw_o),
    .valid_peripheral_select_n_i(valid_peripheral_select_n_o), .enable_i(enable_o),
    .data_i(data_o), .sync_peripheral_request_n_o(sync_peripheral_request_n_i),
    .alt_select_n_o(alt_select_n), .data_o(data_i));
  always @(negedge clk_sys_i) begin
    if (alt_select_n === 1'b0) alt_seen = 1'b1;
  end
  // --------
  // helpers
  // --------
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic up, input logic lo);
    merge = {up ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
  endfunction
  // one request offered while idle, held one core edge, then wait for done
  task automatic run(input sync_bus_pkg::bus_req_type r,
                     output sync_bus_pkg::bus_rsp_type s);
    @(negedge clk_core_i);
    while (core_busy_o !== 1'b0) @(negedge clk_core_i);
    core_req_i = r;
    core_req_valid_i = 1'b1;
    @(negedge clk_core_i);
    core_req_valid_i = 1'b0;
    while (core_done_o !== 1'b1) @(negedge clk_core_i);
    s = core_rsp_o;
  endtask
  // hang guard: ten times the expected run length
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  // --------
  // main sequence
  // --------
  initial begin
    sync_bus_pkg::bus_req_type r;
    sync_bus_pkg::bus_rsp_type s;
    logic [3:0] idx;
    void'($urandom(18));
    repeat (5) @(negedge clk_core_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    @(negedge clk_sys_i);
    check("enable after reset", {31'h0, enable_o}, 32'h0);
    check("select after reset", {31'h0, valid_peripheral_select_n_o}, 32'h1);
    repeat (4) @(negedge clk_core_i);
    // prompt and very late requests first, then random ones
    for (int i = 0; i < 12; i++) begin
      r = '0;
      idx = 4'($urandom_range(15));
      r.addr = {3'h7, 16'h0000, idx};
      r.fc = 3'h5;
      r.wdata = 16'($urandom);
      r.write = 1'b1;
      r.upper = (i % 3) != 1;
      r.lower = (i % 3) != 2;
      req_delay = (i < 2) ? 5'(i * 30) : 5'($urandom_range(12));
      shadow[idx] = merge(shadow[idx], r.wdata, r.upper, r.lower);
      run(r, s);
      check("external select idle", {31'h0, alt_select_n}, 32'h1);
      if (i == 1) check("external select seen", {31'h0, alt_seen}, 32'h1);
      r.write = 1'b0;
      r.upper = 1'b1;
      r.lower = 1'b1;
      run(r, s);
      check("read data", {16'h0, s.rdata}, {16'h0, shadow[idx]});
      check("read low byte", {24'h0, s.vector}, {24'h0, shadow[idx][7:0]});
    end
    // levels one to seven; address kept outside the peripheral area
    for (int l = 1; l < 8; l++) begin
      r = '0;
      r.iack = 1'b1;
      r.lower = 1'b1;
      r.level = 3'(l);
      r.addr = {20'h00000, 3'(l)};
      req_delay = 5'($urandom_range(6));
      run(r, s);
      check("autovector", {24'h0, s.vector}, {24'h0, 8'h18 + {5'h00, 3'(l)}});
      check("autovector flag", {31'h0, s.autovec}, 32'h1);
    end
    summarize();
  end
endmodule

bind sync_peripheral_bus_cycle sync_bus_chk u_sync_bus_chk (
  .clk_sys_i, .rst_i, .sync_peripheral_request_n_i, .data_oe_o, .addr_oe_o, .fc_oe_o,
  .addr_valid_strobe_n_o, .upper_byte_strobe_n_o, .lower_byte_strobe_n_o, .rw_o,
  .valid_peripheral_select_n_o, .enable_o);
